// ===== rtl/uet_top.sv
// USB endpoint transaction unit: register slave, token answers, endpoint flags
// Functional notes
// R01 - Mode compound, hub or function; 0-2 ports
// R02 - Each endpoint owns an 8-byte FIFO
// R03 - Control plus two endpoints; third without hub
// R04 - Enabled endpoints receive; address 0 at start
// R05 - Control stage tracker idles after power-up
// R06 - SETUP data stored, ACKed, setup flag set
// R07 - IN NAKs until loaded, resends until ACK
// R08 - Host ACK clears loaded, sets done
// R09 - Status IN answered with zero-length DATA1
// R10 - Status OUT NAKed while done flag set
// R11 - OUT data stored, ACKed, receive flag set
// R12 - Unreleased OUT FIFO answers NAK
// R13 - Hardware handles retries and data toggles
// R14 - SETUP token clears last-stage flag
// R15 - Hub control endpoint uses same sequence
// R16 - Firmware steers stages after setup interrupt
// R17 - Firmware clears interrupt via acknowledge bits
// R18 - Firmware applies address after status stage
// R19 - Firmware refills or ends read data stage
// R20 - Firmware sets direction, type, enable first
// R21 - New address live only after apply
// R22 - Byte count includes two CRC bytes
// R23 - Force-stall answers unexpected stage with STALL
`include "uet_map.svh"
module uet_top
  import uet_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decoded packets from the serial interface engine
  input wire logic tok_stb,
  input wire uet_tok_type tok_pid,
  input wire logic [6:0] tok_addr,
  input wire logic [3:0] tok_ep,
  input wire logic rx_stb,
  input wire logic [7:0] rx_byte,
  input wire logic rx_done,
  input wire logic rx_abort,
  input wire logic rx_pid_data1,
  input wire logic hs_in_ack,
  input wire logic tx_pop,
  // Answers to the serial interface engine
  output logic hs_stb,
  output uet_hs_type hs_code,
  output logic tx_start,
  output logic tx_pid1,
  output logic [$clog2(FIFO_DEPTH):0] tx_len,
  output logic [7:0] tx_byte,
  // Configuration and interrupt level
  output logic [1:0] mode_sel,
  output logic [1:0] hub_port_count,
  output logic usb_irq
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  // Endpoint slots: 0 hub control or third function endpoint, 1..3 function 0..2
  logic [3:0] en, tog, dir, rxo, txd, stp, txl, stl, lst, isr;
  logic [1:0] typ [4];
  logic [6:0] hpend, hlive, fpend, flive;
  logic happly, fapply;
  uet_txn_type txn;
  logic [1:0] cur;
  logic keep, is_setup, is_stat, zlp;
  uet_hs_type resp;
  logic [7:0] head [4];
  logic [LW-1:0] lvl [4];

  // Register decode
  wire act = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = act && wb_we_i && wb_sel_i[0];
  wire rd = act && !wb_we_i;
  wire [7:0] wd = wb_dat_i[7:0];
  wire is_ep = wb_adr_i[7:6] == `UET_EP_PAGE;
  wire [1:0] asl = wb_adr_i[5:4];
  wire [3:0] asub = wb_adr_i[3:0];
  wire [3:0] a_oh = {4{is_ep}} & (4'h1 << asl);
  wire [3:0] wcf = {4{wr && asub == `UET_EP_CFG}} & a_oh;
  wire [3:0] wst = {4{wr && asub == `UET_EP_STAT}} & a_oh;
  wire [3:0] cpu_push = {4{wr && asub == `UET_EP_DATA}} & a_oh;
  wire [3:0] cpu_pop = {4{rd && asub == `UET_EP_DATA}} & a_oh;
  wire w_glob = wr && !is_ep;

  // Read selection; unmapped offsets answer zero
  wire [7:0] stat_rd = {1'b0, lst[asl], stl[asl], txl[asl], 1'b0, stp[asl], txd[asl],
    rxo[asl]};
  wire [5:0] cnt_rd = 6'(lvl[asl]) + `UET_CRC_BYTES; // see R22
  wire [7:0] ep_rd = asub == `UET_EP_CFG ? {en[asl], 3'h0, tog[asl], dir[asl], typ[asl]} :
    asub == `UET_EP_STAT ? stat_rd : asub == `UET_EP_DATA ? head[asl] :
    asub == `UET_EP_CNT ? {2'h0, cnt_rd} : 8'h00;
  wire [7:0] gl_rd = wb_adr_i == `UET_OFS_CFG ? {4'h0, hub_port_count, mode_sel} :
    wb_adr_i == `UET_OFS_HADDR ? {happly, hpend} :
    wb_adr_i == `UET_OFS_FADDR ? {fapply, fpend} :
    wb_adr_i == `UET_OFS_ISR ? {4'h0, isr} : 8'h00;
  wire [7:0] rdata = is_ep ? ep_rd : gl_rd;

  // Endpoint routing; hub wins when both addresses match
  wire hub_on = mode_sel != UET_MODE_FUNC; // see R01
  wire func_on = mode_sel != UET_MODE_HUB;
  wire hub_hit = hub_on && tok_addr == hlive && tok_ep == 4'h0; // see R04
  wire fa = func_on && tok_addr == flive && !hub_hit;
  wire [3:0] hit_raw = {fa && tok_ep == 4'h2, fa && tok_ep == 4'h1, fa && tok_ep == 4'h0,
    hub_hit || (!hub_on && fa && tok_ep == 4'h3)}; // see R03
  wire [3:0] hit_oh = hit_raw & en;
  wire [1:0] ts = hit_oh[0] ? 2'd0 : hit_oh[1] ? 2'd1 : hit_oh[2] ? 2'd2 : 2'd3;
  wire ctl_t = ts == 2'd1 || (ts == 2'd0 && hub_on);
  wire h_dok, h_sok, f_dok, f_sok;
  wire dok = ts == 2'd0 ? h_dok : f_dok;
  wire sok = ts == 2'd0 ? h_sok : f_sok;
  wire t_in = tok_pid == UET_TOK_IN;
  wire t_out = tok_pid == UET_TOK_OUT;
  wire t_set = tok_pid == UET_TOK_SETUP;
  wire take = tok_stb && |hit_oh && txn != UET_TXN_RX && (!t_set || ctl_t);
  wire [3:0] t_oh = 4'h1 << ts;

  // Answer choice for the token just taken
  wire legal = t_in ? (dok && dir[ts]) || (sok && !dir[ts]) :
    (dok && !dir[ts]) || (sok && dir[ts]);
  wire refuse = ctl_t && stl[ts] && !legal; // see R23
  wire in_zlp = t_in && ctl_t && sok && !dir[ts]; // see R09
  wire in_send = t_in && txl[ts] && dir[ts] && (!ctl_t || dok); // see R07
  wire out_stat = t_out && ctl_t && sok && dir[ts];
  wire out_data = t_out && !dir[ts] && (!ctl_t || dok);
  wire uet_hs_type out_resp = out_stat ? (txd[ts] ? UET_HS_NAK : UET_HS_ACK) : // see R10
    out_data ? (rxo[ts] ? UET_HS_NAK : UET_HS_ACK) : // see R12
    refuse ? UET_HS_STALL : UET_HS_NAK;
  wire keep_new = t_set || (out_data && !rxo[ts]);

  // Completion events of the running transaction
  wire [3:0] c_oh = 4'h1 << cur;
  wire done_ok = txn == UET_TXN_RX && rx_done && resp == UET_HS_ACK;
  wire dup = done_ok && !is_setup && !is_stat && rx_pid_data1 != tog[cur]; // see R13
  wire ev_setup = done_ok && is_setup;
  wire ev_rxout = done_ok && !is_setup && !dup;
  wire ev_ack = txn == UET_TXN_WAIT && hs_in_ack;
  wire ev_stat = (ev_ack && zlp) || (ev_rxout && is_stat);
  wire ev_data = (ev_ack && !zlp) || (ev_rxout && !is_stat);
  wire [3:0] set_stp = {4{ev_setup}} & c_oh; // see R06
  wire [3:0] set_rxo = {4{ev_rxout}} & c_oh; // see R11
  wire [3:0] set_txd = {4{ev_ack}} & c_oh; // see R08
  wire [3:0] clr_txl = {4{ev_ack && !zlp}} & c_oh;
  wire [3:0] clr_lst = {4{take && t_set}} & t_oh; // see R14
  wire [3:0] flip = {4{ev_data}} & c_oh; // see R13
  wire [3:0] fclr = ({4{take && keep_new}} & t_oh) |
    ({4{dup || (txn == UET_TXN_RX && rx_abort && keep)}} & c_oh);
  wire [3:0] frew = {4{take && in_send}} & t_oh; // see R07
  wire [3:0] usb_wr = {4{txn == UET_TXN_RX && keep && rx_stb}} & c_oh;
  wire [3:0] usb_rd = {4{txn == UET_TXN_WAIT && tx_pop}} & c_oh;

  // Hardware sets win over firmware writes; hardware clears win over firmware
  wire [3:0] next_rxo = (rxo & ~wst) | (wst & {4{wd[`UET_B_RXOUT]}}) | set_rxo;
  wire [3:0] next_txd = (txd & ~wst) | (wst & {4{wd[`UET_B_TXDONE]}}) | set_txd;
  wire [3:0] next_stp = (stp & ~wst) | (wst & {4{wd[`UET_B_SETUP]}}) | set_stp;
  wire [3:0] next_txl = ((txl & ~wst) | (wst & {4{wd[`UET_B_TXLOAD]}})) & ~clr_txl;
  wire [3:0] next_stl = (stl & ~wst) | (wst & {4{wd[`UET_B_STALL]}});
  wire [3:0] next_lst = ((lst & ~wst) | (wst & {4{wd[`UET_B_LAST]}})) & ~clr_lst;
  wire [3:0] next_tog = (((tog & ~wcf) | (wcf & {4{wd[`UET_B_TOG]}})) ^ flip) | set_stp;
  wire [3:0] iack = (w_glob && wb_adr_i == `UET_OFS_IACK) ? wd[3:0] : 4'h0;
  wire [3:0] next_isr = (isr & ~iack) | set_stp | set_rxo | set_txd;
  wire h_apply = happly && txd[0]; // see R21
  wire f_apply = fapply && txd[1]; // see R21

  // Endpoint FIFOs, USB side has priority over firmware access
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ep
      uet_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo ( // see R02
        .core_clk(core_clk),
        .resetn(resetn),
        .clr(fclr[gi]),
        .rewind(frew[gi]),
        .wr_en(usb_wr[gi] || cpu_push[gi]),
        .wr_data(usb_wr[gi] ? rx_byte : wd),
        .rd_en(usb_rd[gi] || cpu_pop[gi]),
        .rd_data(head[gi]),
        .level(lvl[gi])
      );
    end
  endgenerate

  // Stage trackers for hub and function control endpoints
  uet_ctl_fsm u_hub_ctl (
    .core_clk(core_clk),
    .resetn(resetn),
    .setup_evt(set_stp[0] && hub_on),
    .data_evt(ev_data && cur == 2'd0),
    .status_evt(ev_stat && cur == 2'd0),
    .last_stage(lst[0]),
    .data_ok(h_dok),
    .status_ok(h_sok)
  );
  uet_ctl_fsm u_func_ctl (
    .core_clk(core_clk),
    .resetn(resetn),
    .setup_evt(set_stp[1]),
    .data_evt(ev_data && cur == 2'd1),
    .status_evt(ev_stat && cur == 2'd1),
    .last_stage(lst[1]),
    .data_ok(f_dok),
    .status_ok(f_sok)
  );

  // Bus answer one cycle after the request
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= act;
      if (rd)
        wb_dat_o <= {24'h0, rdata};
    end

  // Flags, toggles and interrupt status
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      {rxo, txd, stp, txl, stl, lst, tog, isr} <= '0;
      usb_irq <= 1'b0;
    end
    else
    begin
      {rxo, txd, stp, txl, stl, lst} <= {next_rxo, next_txd, next_stp, next_txl, next_stl,
        next_lst};
      tog <= next_tog;
      isr <= next_isr; // see R17
      usb_irq <= |next_isr;
    end

  // Endpoint configuration; enabled endpoints start out receiving
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      en <= 4'h0;
      dir <= 4'h0;
      for (int i = 0; i < 4; i++)
        typ[i] <= 2'h0;
    end
    else
      for (int i = 0; i < 4; i++)
        if (wcf[i])
        begin
          en[i] <= wd[`UET_B_EN];
          dir[i] <= wd[`UET_B_DIR]; // see R04
          typ[i] <= wd[1:0];
        end

  // Mode, port count and addresses; live addresses stay 0 until applied
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      mode_sel <= UET_MODE_COMPOUND;
      hub_port_count <= 2'h0;
      {happly, hpend, fapply, fpend} <= {`UET_RST_BYTE, `UET_RST_BYTE};
      hlive <= 7'h00;
      flive <= 7'h00;
    end
    else
    begin
      if (w_glob && wb_adr_i == `UET_OFS_CFG)
      begin
        mode_sel <= wd[1:0] == 2'h3 ? UET_MODE_COMPOUND : wd[1:0]; // see R01
        hub_port_count <= wd[3:2] > `UET_MAX_PORTS ? `UET_MAX_PORTS : wd[3:2];
      end
      if (w_glob && wb_adr_i == `UET_OFS_HADDR)
        {happly, hpend} <= wd;
      else if (h_apply)
      begin
        hlive <= hpend;
        happly <= 1'b0;
      end
      if (w_glob && wb_adr_i == `UET_OFS_FADDR)
        {fapply, fpend} <= wd;
      else if (f_apply)
      begin
        flive <= fpend;
        fapply <= 1'b0;
      end
    end

  // Transaction sequencer; a new token while awaiting ACK is a host retry
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      txn <= UET_TXN_IDLE;
      {cur, keep, is_setup, is_stat, zlp, hs_stb, tx_start, tx_pid1} <= '0;
      resp <= UET_HS_ACK;
      hs_code <= UET_HS_ACK;
      tx_len <= '0;
      tx_byte <= 8'h00;
    end
    else
    begin
      hs_stb <= 1'b0;
      tx_start <= 1'b0;
      tx_byte <= head[cur];
      case (txn)
        UET_TXN_IDLE, UET_TXN_WAIT:
          if (take)
          begin
            cur <= ts;
            keep <= keep_new;
            is_setup <= t_set;
            is_stat <= out_stat;
            resp <= t_set ? UET_HS_ACK : out_resp;
            zlp <= in_zlp;
            if (!t_in)
              txn <= UET_TXN_RX;
            else if (in_send || in_zlp)
            begin
              tx_start <= 1'b1;
              tx_pid1 <= in_zlp || tog[ts]; // see R09
              tx_len <= in_zlp ? '0 : lvl[ts];
              txn <= UET_TXN_WAIT;
            end
            else
            begin
              hs_stb <= 1'b1;
              hs_code <= refuse ? UET_HS_STALL : UET_HS_NAK; // see R07
              txn <= UET_TXN_IDLE;
            end
          end
          else if (ev_ack)
            txn <= UET_TXN_IDLE;
        UET_TXN_RX:
          if (rx_done)
          begin
            hs_stb <= 1'b1;
            hs_code <= resp; // see R06
            txn <= UET_TXN_IDLE;
          end
          else if (rx_abort)
            txn <= UET_TXN_IDLE;
        default: txn <= UET_TXN_IDLE;
      endcase
    end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_setup_end;
    txn == UET_TXN_RX && is_setup && rx_done;
  endsequence
  sequence s_stat_nak_end;
    txn == UET_TXN_RX && is_stat && resp == UET_HS_NAK && rx_done;
  endsequence
  a_setup_ack: assert property (s_setup_end |=> hs_stb && hs_code == UET_HS_ACK // see R06
    && stp[$past(cur)] && tog[$past(cur)])
    else $error("setup not acknowledged and flagged");
  a_in_nak: assert property (take && t_in && !txl[ts] && !in_zlp // see R07
    |=> hs_stb && hs_code != UET_HS_ACK && !tx_start)
    else $error("IN without loaded data not refused");
  a_in_done: assert property (ev_ack && !zlp |=> txd[$past(cur)] && !txl[$past(cur)]) // see R08
    else $error("ACKed IN did not update flags");
  a_zlp_data1: assert property (tx_start && zlp |-> tx_pid1 && tx_len == '0) // see R09
    else $error("status IN not zero-length DATA1");
  a_stat_nak: assert property (s_stat_nak_end |=> hs_code == UET_HS_NAK // see R10
    && !rxo[$past(cur)] ##1 !hs_stb)
    else $error("status OUT not refused");
  // Helper: a refused OUT stays pending until its handshake goes out
  logic nak_due;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      nak_due <= 1'b0;
    else if (take)
      nak_due <= out_data && rxo[ts];
    else if (hs_stb)
      nak_due <= 1'b0;
  a_out_busy: assert property (nak_due && hs_stb |-> hs_code == UET_HS_NAK) // see R12
    else $error("unreleased OUT FIFO accepted data");
  a_last_clear: assert property (take && t_set |=> !lst[$past(ts)]) // see R14
    else $error("setup token left last-stage set");
  a_addr_apply: assert property ($changed(hlive) |-> $past(happly && txd[0])) // see R21
    else $error("hub address changed without apply");
  a_port_limit: assert property (hub_port_count <= `UET_MAX_PORTS) // see R01
    else $error("port count above two");
  a_bus_ack: assert property (act |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not single cycle");
endmodule

// ===== rtl/uet_map.svh
// Register offsets, field positions and reset values of the endpoint unit
`ifndef UET_MAP_SVH
`define UET_MAP_SVH
`define UET_OFS_CFG 8'h00
`define UET_OFS_HADDR 8'h04
`define UET_OFS_FADDR 8'h08
`define UET_OFS_ISR 8'h0C
`define UET_OFS_IACK 8'h10
`define UET_EP_PAGE 2'h1
`define UET_EP_CFG 4'h0
`define UET_EP_STAT 4'h4
`define UET_EP_DATA 4'h8
`define UET_EP_CNT 4'hC
`define UET_B_EN 7
`define UET_B_TOG 3
`define UET_B_DIR 2
`define UET_B_RXOUT 0
`define UET_B_TXDONE 1
`define UET_B_SETUP 2
`define UET_B_TXLOAD 4
`define UET_B_STALL 5
`define UET_B_LAST 6
`define UET_B_APPLY 7
`define UET_RST_BYTE 8'h00
`define UET_MAX_PORTS 2'h2
`define UET_CRC_BYTES 6'h02
`endif

// ===== rtl/uet_pkg.sv
// Types shared by the endpoint transaction unit
package uet_pkg;
  typedef enum logic [1:0] {UET_TOK_OUT = 2'b00, UET_TOK_IN = 2'b01,
    UET_TOK_SETUP = 2'b10} uet_tok_type;
  typedef enum logic [1:0] {UET_HS_ACK = 2'b00, UET_HS_NAK = 2'b01,
    UET_HS_STALL = 2'b10} uet_hs_type;
  typedef enum logic [1:0] {UET_TXN_IDLE = 2'b00, UET_TXN_RX = 2'b01,
    UET_TXN_WAIT = 2'b10} uet_txn_type;
  typedef enum logic [1:0] {UET_CTL_IDLE = 2'b00, UET_CTL_SETUP = 2'b01,
    UET_CTL_DATA = 2'b10} uet_ctl_type;
  typedef enum logic [1:0] {UET_MODE_COMPOUND = 2'b00, UET_MODE_HUB = 2'b01,
    UET_MODE_FUNC = 2'b10} uet_mode_type;
endpackage

// ===== rtl/uet_fifo.sv
// Per-endpoint packet FIFO with rewind for retries
module uet_fifo
  import uet_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic clr,
  input wire logic rewind,
  // Write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire full = wp == (AW+1)'(DEPTH);
  wire has_data = rp != wp;

  // Level is the packet size; reads do not shrink it so a retry resends all
  assign level = wp;
  assign rd_data = mem[rp[AW-1:0]];

  // Pointers
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else if (clr)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (wr_en && !full)
        wp <= wp + 1'b1;
      if (rewind)
        rp <= '0;
      else if (rd_en && has_data)
        rp <= rp + 1'b1;
    end

  // Storage, no reset needed
  always_ff @(posedge core_clk)
    if (wr_en && !full && !clr)
      mem[wp[AW-1:0]] <= wr_data;

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (!resetn) // see R02
    level <= (AW+1)'(DEPTH) && rp <= wp)
    else $error("fifo pointer out of range");
endmodule

// ===== rtl/uet_ctl_fsm.sv
// Control transfer stage tracker for one control endpoint
module uet_ctl_fsm
  import uet_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Stage events
  input wire logic setup_evt,
  input wire logic data_evt,
  input wire logic status_evt,
  // Firmware steering
  input wire logic last_stage,
  // Legal stages
  output logic data_ok,
  output logic status_ok
);
  uet_ctl_type state;
  uet_ctl_type next_state;

  // Next stage; a new setup always restarts the transfer
  always_comb
  begin
    next_state = state;
    case (state)
      UET_CTL_IDLE: if (setup_evt) next_state = UET_CTL_SETUP;
      UET_CTL_SETUP, UET_CTL_DATA:
        if (setup_evt)
          next_state = UET_CTL_SETUP;
        else if (status_evt)
          next_state = UET_CTL_IDLE;
        else if (data_evt)
          next_state = UET_CTL_DATA;
      default: next_state = UET_CTL_IDLE;
    endcase
  end

  // Power-up lands in idle; see R05
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      state <= UET_CTL_IDLE;
    else
      state <= next_state;

  // Last-stage bit picks status over data; see R15
  assign data_ok = (state != UET_CTL_IDLE) && !last_stage;
  assign status_ok = (state != UET_CTL_IDLE) && last_stage;

  a_ctl_status_end: assert property (@(posedge core_clk) disable iff (!resetn) // see R15
    status_evt && !setup_evt && state != UET_CTL_IDLE |=> state == UET_CTL_IDLE)
    else $error("status stage did not close transfer");
  a_ctl_idle_hold: assert property (@(posedge core_clk) disable iff (!resetn) // see R05
    state == UET_CTL_IDLE && !setup_evt |=> state == UET_CTL_IDLE)
    else $error("control stage left idle without setup");
endmodule

// ===== test/uet_host_model.sv
// Host-side packet engine model that feeds tokens and data into the unit
module uet_host_model
  import uet_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)
(
  // Clock
  input wire logic core_clk,
  // Packets towards the unit
  output logic tok_stb,
  output uet_tok_type tok_pid,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep,
  output logic rx_stb,
  output logic [7:0] rx_byte,
  output logic rx_done,
  output logic rx_abort,
  output logic rx_pid_data1,
  output logic hs_in_ack,
  output logic tx_pop,
  // Answers from the unit
  input wire logic hs_stb,
  input wire uet_hs_type hs_code,
  input wire logic tx_start,
  input wire logic tx_pid1,
  input wire logic [$clog2(FIFO_DEPTH):0] tx_len,
  input wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // Last outcome: 0-2 handshake code, 4 data packet, 7 silence
  logic [2:0] last_res;
  logic last_pid1;
  logic [$clog2(FIFO_DEPTH):0] last_len;
  logic [7:0] got [8];

  // Idle levels; bad packets are never sent by this model
  initial
  begin
    {tok_stb, rx_stb, rx_done, rx_abort, rx_pid_data1, hs_in_ack, tx_pop} = '0;
    tok_pid = UET_TOK_OUT;
    {tok_addr, tok_ep, rx_byte} = '0;
  end

  // Token, data packet when the token carries one, then the unit's answer
  task automatic xfer(input uet_tok_type pid, input logic [3:0] ep, input int n,
    input logic [7:0] base, input logic d1);
    int i;
    @(posedge core_clk);
    tok_stb <= 1'b1;
    tok_pid <= pid;
    tok_ep <= ep;
    @(posedge core_clk);
    tok_stb <= 1'b0;
    tok_ep <= ~ep; // Stale fields scrambled so nothing leans on them
    if (pid != UET_TOK_IN)
    begin
      // Bytes back to back, then the end-of-packet strobe
      for (i = 0; i < n; i++)
      begin
        rx_stb <= 1'b1;
        rx_byte <= base + 8'(i);
        @(posedge core_clk);
      end
      rx_stb <= 1'b0;
      rx_byte <= ~rx_byte;
      rx_done <= 1'b1;
      rx_pid_data1 <= d1;
      @(posedge core_clk);
      rx_done <= 1'b0;
    end
    last_res = 3'h7;
    for (i = 0; i < 12 && last_res == 3'h7; i++)
    begin
      @(posedge core_clk);
      if (hs_stb === 1'b1)
        last_res = {1'b0, hs_code};
      else if (tx_start === 1'b1)
      begin
        last_res = 3'h4;
        last_pid1 = tx_pid1;
        last_len = tx_len;
      end
    end
    // Engine drains the packet one byte per pop
    if (last_res == 3'h4)
      for (i = 0; i < int'(last_len) && i < 8; i++)
      begin
        repeat (2) @(posedge core_clk);
        got[i] = tx_byte;
        tx_pop <= 1'b1;
        @(posedge core_clk);
        tx_pop <= 1'b0;
      end
  endtask

  // Host accepts the last data packet
  task automatic host_ack();
    @(posedge core_clk);
    hs_in_ack <= 1'b1;
    @(posedge core_clk);
    hs_in_ack <= 1'b0;
  endtask
endmodule

// ===== test/test_usb_endpoint_transaction_unit.sv
// Self-checking bench for the endpoint transaction unit
module test_usb_endpoint_transaction_unit
  import uet_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic we; logic [7:0] adr; logic [7:0] wd;} uet_row_type;
  logic core_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic tok_stb, rx_stb, rx_done, rx_abort, rx_pid_data1, hs_in_ack, tx_pop;
  uet_tok_type tok_pid;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep, tx_len;
  logic [7:0] rx_byte, tx_byte;
  logic hs_stb, tx_start, tx_pid1, usb_irq;
  uet_hs_type hs_code;
  logic [1:0] mode_sel, hub_port_count;
  int errors = 0;
  int cmp_count = 0;
  // Reset reads, setup of slots, readbacks; wd is the expected value on reads
  localparam uet_row_type ROWS [12] = '{'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00},
    '{1'b0, 8'h0C, 8'h00}, '{1'b0, 8'h30, 8'h00}, '{1'b1, 8'h00, 8'h0E},
    '{1'b0, 8'h00, 8'h0A}, '{1'b1, 8'h50, 8'h80}, '{1'b1, 8'h60, 8'h87},
    '{1'b0, 8'h60, 8'h87}, '{1'b1, 8'h70, 8'h82}, '{1'b0, 8'h4C, 8'h02},
    '{1'b1, 8'h54, 8'h40}};

  uet_top #(.FIFO_DEPTH(8)) dut_u (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tok_stb, .tok_pid, .tok_addr,
    .tok_ep, .rx_stb, .rx_byte, .rx_done, .rx_abort, .rx_pid_data1, .hs_in_ack, .tx_pop,
    .hs_stb, .hs_code, .tx_start, .tx_pid1, .tx_len, .tx_byte, .mode_sel,
    .hub_port_count, .usb_irq);

  uet_host_model #(.FIFO_DEPTH(8)) host_u (.core_clk, .tok_stb, .tok_pid, .tok_addr,
    .tok_ep, .rx_stb, .rx_byte, .rx_done, .rx_abort, .rx_pid_data1, .hs_in_ack, .tx_pop,
    .hs_stb, .hs_code, .tx_start, .tx_pid1, .tx_len, .tx_byte);

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Classic single cycle; waits for ack under a bound, no fixed latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (n == 20)
    begin
      errors++;
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  // Token exchange and comparison of the unit's answer
  task automatic ex(input uet_tok_type p, input logic [3:0] ep, input int n,
    input logic [7:0] b, input logic d1, input logic [2:0] exp);
    host_u.xfer(p, ep, n, b, d1);
    check(host_u.last_res, exp);
  endtask

  initial
  begin
    {core_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = '0;
    wb_sel_i = 4'hF;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    for (int r = 0; r < 12; r++)
      if (ROWS[r].we)
        wb(1'b1, ROWS[r].adr, ROWS[r].wd);
      else
        rdc(ROWS[r].adr, ROWS[r].wd);
    check(mode_sel, 2);
    check(hub_port_count, 2);
    // Setup on control endpoint clears last-stage and raises interrupt
    ex(UET_TOK_SETUP, 4'h0, 8, 8'h10, 1'b0, 3'h0);
    rdc(8'h54, 8'h04);
    rdc(8'h5C, 8'h0A);
    rdc(8'h58, 8'h10);
    rdc(8'h0C, 8'h02);
    check(usb_irq, 1);
    wb(1'b1, 8'h10, 8'h02);
    rdc(8'h0C, 8'h00);
    check(usb_irq, 0);
    // IN endpoint: NAK while empty, resend on retry, done after ACK
    ex(UET_TOK_IN, 4'h1, 0, 8'h00, 1'b0, 3'h1);
    wb(1'b1, 8'h68, 8'hAA);
    wb(1'b1, 8'h68, 8'hBB);
    wb(1'b1, 8'h64, 8'h10);
    for (int k = 0; k < 2; k++)
    begin
      ex(UET_TOK_IN, 4'h1, 0, 8'h00, 1'b0, 3'h4);
      check({host_u.last_len, host_u.last_pid1}, {4'h2, 1'b0});
      check({host_u.got[0], host_u.got[1]}, 16'hAABB);
    end
    host_u.host_ack();
    rdc(8'h64, 8'h02);
    rdc(8'h60, 8'h8F);
    ex(UET_TOK_IN, 4'h1, 0, 8'h00, 1'b0, 3'h1);
    // OUT endpoint: ACK, NAK until released, toggle follows
    ex(UET_TOK_OUT, 4'h2, 3, 8'h30, 1'b0, 3'h0);
    rdc(8'h74, 8'h01);
    rdc(8'h7C, 8'h05);
    rdc(8'h78, 8'h30);
    ex(UET_TOK_OUT, 4'h2, 3, 8'h40, 1'b1, 3'h1);
    wb(1'b1, 8'h74, 8'h00);
    ex(UET_TOK_OUT, 4'h2, 2, 8'h50, 1'b1, 3'h0);
    rdc(8'h74, 8'h01);
    // Control read status: NAK while the done flag stands, ACK once cleared
    ex(UET_TOK_SETUP, 4'h0, 8, 8'h20, 1'b0, 3'h0);
    wb(1'b1, 8'h50, 8'h84);
    wb(1'b1, 8'h54, 8'h62);
    ex(UET_TOK_OUT, 4'h0, 0, 8'h00, 1'b1, 3'h1);
    wb(1'b1, 8'h54, 8'h60);
    ex(UET_TOK_OUT, 4'h0, 0, 8'h00, 1'b1, 3'h0);
    rdc(8'h54, 8'h61);
    // No-data transfer: stray OUT stalls, empty status packet, address goes live
    ex(UET_TOK_SETUP, 4'h0, 8, 8'h20, 1'b0, 3'h0);
    wb(1'b1, 8'h50, 8'h80);
    wb(1'b1, 8'h54, 8'h60);
    wb(1'b1, 8'h08, 8'h85);
    rdc(8'h08, 8'h85);
    ex(UET_TOK_OUT, 4'h0, 0, 8'h00, 1'b1, 3'h2);
    ex(UET_TOK_IN, 4'h0, 0, 8'h00, 1'b0, 3'h4);
    check({host_u.last_len, host_u.last_pid1}, {4'h0, 1'b1});
    host_u.host_ack();
    rdc(8'h54, 8'h62);
    rdc(8'h08, 8'h05);
    ex(UET_TOK_IN, 4'h1, 0, 8'h00, 1'b0, 3'h7);
    // Reset mid-run returns configuration and slots to idle
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(8'h00, 8'h00);
    check(mode_sel, 0);
    rdc(8'h60, 8'h00);
    ex(UET_TOK_IN, 4'h1, 0, 8'h00, 1'b0, 3'h7);
    conclude();
  end
endmodule
